/* ttc_pkg.sv */
// Constants shared by the tamper time-stamp clock register block
package ttc_pkg;

	// Clock and oscillator rates
	localparam int CLK_HZ = 250_000_000;
	localparam int OSC_HZ = 32768;
	localparam int OSC_CYCLES = CLK_HZ / OSC_HZ;
	localparam int SUBSEC_PER_SEC = 100;
	localparam int SAMPLE_WIN_MS = 1;
	localparam int SAMPLE_WIN_TICKS = (OSC_HZ * SAMPLE_WIN_MS + 999) / 1000;

	// Register offsets
	localparam logic [7:0] ADDR_SUBSEC = 8'h00;
	localparam logic [7:0] ADDR_SECONDS = 8'h01;
	localparam logic [7:0] ADDR_HOURS = 8'h03;
	localparam logic [7:0] ADDR_WEEKDAY = 8'h04;
	localparam logic [7:0] ADDR_YEAR = 8'h07;
	localparam logic [7:0] ADDR_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_HALT = 8'h0c;
	localparam logic [7:0] ADDR_FLAGS = 8'h0f;
	localparam logic [7:0] ADDR_TAMPER1 = 8'h14;
	localparam logic [7:0] ADDR_TAMPER2 = 8'h15;

	// Field positions
	localparam int STOP_BIT = 7;
	localparam int HALT_BIT = 6;
	localparam int CENTURY_LSB = 6;
	localparam int FLAG_CH1_BIT = 1;
	localparam int FLAG_CH2_BIT = 0;
	localparam int TCFG_ARM = 7;
	localparam int TCFG_IRQ_EN = 6;
	localparam int TCFG_SWITCH_MODE = 5;
	localparam int TCFG_POLARITY = 4;
	localparam int TCFG_SAMPLE = 3;
	localparam int TCFG_STRENGTH = 2;

	// Reset values (year, month, date, weekday, hours, minutes, seconds, subsecond)
	localparam logic [7:0][7:0] RST_TIME = {8'h00, 8'h01, 8'h01, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_TCFG = 8'h00;

endpackage : ttc_pkg

/* ttc_osc_div.sv */
// Oscillator divider chain: 32 kHz tick, subsecond tick and sampling window
`timescale 1ns/100ps
module ttc_osc_div
	import ttc_pkg::*;
#(
	parameter int OSC_DIV = OSC_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic div_reset,
	// Timing outputs
	output logic tick_subsec,
	output logic sample_win
);

	localparam int PW = $clog2(OSC_DIV);

	generate
		if (OSC_DIV < 2) begin : g_bad_div
			$error("OSC_DIV must be at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [PW-1:0] pre;
		logic [14:0] sec_cnt;
		logic [15:0] acc;
		logic tick;
	} ttc_div_s;

	ttc_div_s st_reg;
	ttc_div_s st_next;

	// Prescale the system clock to the oscillator rate, then split seconds
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (div_reset) begin
			st_next.pre = '0;
			st_next.sec_cnt = '0;
			st_next.acc = '0;
		end else if (run) begin
			if (st_reg.pre == PW'(OSC_DIV - 1)) begin
				st_next.pre = '0;
				st_next.sec_cnt = st_reg.sec_cnt + 15'h0001;
				// Fractional accumulator gives exactly 100 ticks per second
				if (st_reg.acc + 16'(SUBSEC_PER_SEC) >= 16'(OSC_HZ)) begin
					st_next.acc = st_reg.acc + 16'(SUBSEC_PER_SEC) - 16'(OSC_HZ);
					st_next.tick = 1'b1;
				end else begin
					st_next.acc = st_reg.acc + 16'(SUBSEC_PER_SEC);
				end
			end else begin
				st_next.pre = st_reg.pre + PW'(1);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sample_win = (st_reg.sec_cnt < 15'(SAMPLE_WIN_TICKS));
	assign tick_subsec = st_reg.tick;

endmodule : ttc_osc_div

/* ttc_tamper_clock.sv */
// Tamper detection, time-stamp freeze and clock register file
`timescale 1ns/100ps

// Contract
// - Normally-open: switch drives polarity level, tamper
// - Normally-closed: pull reaching polarity level, tamper
// - Armed channel event sets its flag
// - Flag with interrupt enable asserts irq_n
// - Flags read, enable clear, reset release irq
// - Flag cleared only by arm write zero
// - Detection works on main and battery power
// - Sampled mode checks once per second, 1ms; normally-open checks continuously
// - Disarmed or tripped channel stops monitoring
// - Stopped oscillator forces continuous monitoring
// - Tamper freezes user clock register updates
// - Updates resume only with both arms zero
// - Multiple tampers keep first time-stamp
// - Armed tamper blocks power-down halt-update
// - Clock writes zero subsecond, only 00 accepted
// - Century, weekday and calendar fields layout BCD
// - Stop bit halts oscillator, clearing restarts
// - Clock write loads system time, resets divider
// - Periodic copy paused on access and battery
// - Power-down sets halt-update; zero resumes
// - Halt or tamper zeros subsecond, time continues
module ttc_tamper_clock
	import ttc_pkg::*;
#(
	parameter int OSC_DIV = OSC_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port from the serial front end
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_stb,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_stb,
	output logic [7:0] reg_rd_data,
	input wire logic clock_access,
	// Supply and supervisor pins
	input wire logic powerfail_out,
	input wire logic on_battery,
	input wire logic reset_out_active,
	// Tamper pins and pull control
	input wire logic [1:0] tamper_input_pin,
	output logic [1:0] pull_enable,
	output logic [1:0] pull_to_high,
	output logic [1:0] pull_strength_sel,
	// Status outputs
	output logic irq_n,
	output logic osc_enable,
	output logic [1:0] tamper_flag
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [7:0][7:0] user;
		logic [7:0][7:0] sys;
		logic [7:0] control;
		logic [1:0][7:0] tcfg;
		logic [1:0] flag;
		logic freeze;
		logic halt_update;
		logic irq;
		logic [7:0] rdata;
		logic [1:0] pin_s1;
		logic [1:0] pin_s2;
		logic pf_s1;
		logic pf_s2;
		logic pf_prev;
		logic bat_s1;
		logic bat_s2;
		logic rst_s1;
		logic rst_s2;
	} ttc_state_s;

	ttc_state_s st_reg;
	ttc_state_s st_next;

	logic tick_subsec;
	logic sample_win;
	logic div_reset;
	logic clock_wr;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// BCD increment with wrap; bit 8 is the carry into the next field
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] maxv,
		input logic [7:0] minv);
		logic [8:0] r;
		if (v >= maxv) begin
			r = {1'b1, minv};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_step

	// Last day of the month in BCD, leap years every fourth year
	function automatic logic [7:0] month_days(input logic [7:0] month, input logic [7:0] year);
		logic leap;
		leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
			: (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
		case (month)
			8'h02: month_days = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
			default: month_days = 8'h31;
		endcase
	endfunction : month_days

	// True when an address falls in the eight clock registers
	function automatic logic is_clock_addr(input logic [7:0] a);
		return a <= ADDR_YEAR;
	endfunction : is_clock_addr

	////////////////////////////////////////////////////////////////////////////////
	// Divider chain

	assign clock_wr = reg_wr_stb && is_clock_addr(reg_addr);
	assign div_reset = clock_wr;

	ttc_osc_div #(
		.OSC_DIV(OSC_DIV)
	) u_div (
		.clock(clock),
		.rst_n(rst_n),
		.run(osc_enable),
		.div_reset(div_reset),
		.tick_subsec(tick_subsec),
		.sample_win(sample_win)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic [7:0][7:0] t;
		logic [8:0] c;
		logic [1:0] active;
		logic [1:0] event_hit;
		logic [1:0] disarm;
		logic [1:0] irq_off;
		logic pf_edge;
		logic any_arm;
		logic first_tamper;
		t = st_reg.sys;
		c = '0;
		active = '0;
		event_hit = '0;
		disarm = '0;
		irq_off = '0;
		pf_edge = 1'b0;
		any_arm = 1'b0;
		first_tamper = 1'b0;
		st_next = st_reg;

		// Two-stage synchronisers for pins from outside the clock domain
		st_next.pin_s1 = tamper_input_pin;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pf_s1 = powerfail_out;
		st_next.pf_s2 = st_reg.pf_s1;
		st_next.pf_prev = st_reg.pf_s2;
		st_next.bat_s1 = on_battery;
		st_next.bat_s2 = st_reg.bat_s1;
		st_next.rst_s1 = reset_out_active;
		st_next.rst_s2 = st_reg.rst_s1;
		pf_edge = st_reg.pf_s2 && !st_reg.pf_prev;

		// Tamper detection per channel; battery state does not gate it
		for (int i = 0; i < 2; i++) begin
			active[i] = st_reg.tcfg[i][TCFG_ARM] && !st_reg.flag[i]
				&& (st_reg.tcfg[i][TCFG_SWITCH_MODE] || !st_reg.tcfg[i][TCFG_SAMPLE]
				|| !osc_enable || sample_win);
			event_hit[i] = active[i] && (st_reg.pin_s2[i] == st_reg.tcfg[i][TCFG_POLARITY]);
		end

		// Internal time keeps running regardless of freeze or halt
		// internal time continues
		if (tick_subsec && osc_enable) begin
			c = bcd_step(t[0], 8'h99, 8'h00);
			t[0] = c[7:0];
			if (c[8]) begin
				c = bcd_step({1'b0, t[1][6:0]}, 8'h59, 8'h00);
				t[1][6:0] = c[6:0];
				if (c[8]) begin
					c = bcd_step({1'b0, t[2][6:0]}, 8'h59, 8'h00);
					t[2][6:0] = c[6:0];
					if (c[8]) begin
						c = bcd_step({2'b00, t[3][5:0]}, 8'h23, 8'h00);
						t[3][5:0] = c[5:0];
						if (c[8]) begin
							c = bcd_step({5'b00000, t[4][2:0]}, 8'h07, 8'h01);
							t[4][2:0] = c[2:0];
							c = bcd_step({2'b00, t[5][5:0]}, month_days(
								{3'b000, t[6][4:0]}, t[7]), 8'h01);
							t[5][5:0] = c[5:0];
							if (c[8]) begin
								c = bcd_step({3'b000, t[6][4:0]}, 8'h12, 8'h01);
								t[6][4:0] = c[4:0];
								if (c[8]) begin
									c = bcd_step(t[7], 8'h99, 8'h00);
									t[7] = c[7:0];
									if (c[8]) begin
										t[3][7:6] = t[3][7:6] + 2'b01;
									end
								end
							end
						end
					end
				end
			end
		end
		st_next.sys = t;

		if (tick_subsec && !st_reg.freeze && !st_reg.halt_update && !clock_access
			&& !st_reg.bat_s2) begin
			st_next.user = t;
		end

		// Register writes
		if (reg_wr_stb) begin
			if (is_clock_addr(reg_addr)) begin
				st_next.user[reg_addr[2:0]] = reg_wr_data;
				st_next.user[0] = 8'h00;
				st_next.sys = st_next.user;
			end
			case (reg_addr)
				ADDR_CONTROL: st_next.control = reg_wr_data;
				ADDR_HALT: st_next.halt_update = reg_wr_data[HALT_BIT];
				ADDR_TAMPER1, ADDR_TAMPER2: begin
					st_next.tcfg[reg_addr[0]] = reg_wr_data;
					disarm[reg_addr[0]] = !reg_wr_data[TCFG_ARM];
					irq_off[reg_addr[0]] = !reg_wr_data[TCFG_IRQ_EN];
				end
				default: ;
			endcase
		end

		for (int i = 0; i < 2; i++) begin
			if (disarm[i]) begin
				st_next.flag[i] = 1'b0;
			end
			if (event_hit[i]) begin
				st_next.flag[i] = 1'b1;
			end
		end

		if (!st_next.tcfg[0][TCFG_ARM] && !st_next.tcfg[1][TCFG_ARM]) begin
			st_next.freeze = 1'b0;
		end
		first_tamper = (|event_hit) && !st_reg.freeze;
		if (|event_hit) begin
			st_next.freeze = 1'b1;
		end
		if (first_tamper) begin
			st_next.user = st_reg.user;
			st_next.user[0] = 8'h00;
		end

		any_arm = st_reg.tcfg[0][TCFG_ARM] || st_reg.tcfg[1][TCFG_ARM];
		if (pf_edge && !any_arm) begin
			st_next.halt_update = 1'b1;
			st_next.user = st_reg.user;
			st_next.user[0] = 8'h00;
		end

		if ((reg_rd_stb && reg_addr == ADDR_FLAGS) || (|irq_off) || st_reg.rst_s2) begin
			st_next.irq = 1'b0;
		end
		// enabled flag raises irq; set wins over clear
		for (int i = 0; i < 2; i++) begin
			if (event_hit[i] && st_reg.tcfg[i][TCFG_IRQ_EN]) begin
				st_next.irq = 1'b1;
			end
		end

		// Read data is registered; unmapped addresses read as zero
		if (reg_rd_stb) begin
			if (is_clock_addr(reg_addr)) begin
				st_next.rdata = st_reg.user[reg_addr[2:0]];
			end else begin
				case (reg_addr)
					ADDR_CONTROL: st_next.rdata = st_reg.control;
					ADDR_HALT: st_next.rdata = {1'b0, st_reg.halt_update, 6'h00};
					ADDR_FLAGS: st_next.rdata = {6'h00, st_reg.flag[0], st_reg.flag[1]};
					ADDR_TAMPER1: st_next.rdata = st_reg.tcfg[0];
					ADDR_TAMPER2: st_next.rdata = st_reg.tcfg[1];
					default: st_next.rdata = 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.user <= RST_TIME;
			st_reg.sys <= RST_TIME;
			st_reg.control <= RST_CONTROL;
			st_reg.tcfg <= {RST_TCFG, RST_TCFG};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign osc_enable = !st_reg.sys[1][STOP_BIT];
	assign irq_n = !st_reg.irq;
	assign reg_rd_data = st_reg.rdata;
	assign tamper_flag = {st_reg.flag[1], st_reg.flag[0]};

	// Pull drive only in normally-closed mode while monitoring; a sampled
	// channel draws current only inside the window or while the oscillator is stopped
	generate
		for (genvar g = 0; g < 2; g++) begin : g_pull
			assign pull_enable[g] = st_reg.tcfg[g][TCFG_ARM] && !st_reg.flag[g]
				&& !st_reg.tcfg[g][TCFG_SWITCH_MODE]
				&& (!st_reg.tcfg[g][TCFG_SAMPLE] || !osc_enable || sample_win);
			assign pull_to_high[g] = st_reg.tcfg[g][TCFG_POLARITY];
			assign pull_strength_sel[g] = st_reg.tcfg[g][TCFG_STRENGTH];
		end
	endgenerate

endmodule : ttc_tamper_clock

/* ttc_switch_model.sv */
// Tamper switch and wiring model for one channel
`timescale 1ns/100ps
module ttc_switch_model (
	// Switch state and wiring choice
	input wire logic sw_closed,
	input wire logic no_mode,
	input wire logic pol,
	// Pull from the device
	input wire logic pull_en,
	input wire logic pull_hi,
	// Pin level
	output logic pin
);
	// switch drives level
	// An open pin with no pull is given the idle level, not a guess
	always_comb begin
		if (no_mode)
			pin = sw_closed ? pol : ~pol;
		else
			pin = sw_closed ? ~pol : (pull_en ? pull_hi : ~pol);
	end
endmodule : ttc_switch_model

/* ttc_tamper_clock_chk.sv */
// Port checker for the tamper clock block
`timescale 1ns/100ps
module ttc_tamper_clock_chk
	import ttc_pkg::*;
#(
	parameter int OSC_DIV = OSC_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_stb,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_stb,
	input wire logic [7:0] reg_rd_data,
	// Status
	input wire logic irq_n,
	input wire logic osc_enable,
	input wire logic [1:0] tamper_flag,
	input wire logic [1:0] pull_enable
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// Access sequences
	sequence clk_wr;
		reg_wr_stb && reg_addr <= ADDR_YEAR;
	endsequence
	sequence sub_rd;
		reg_rd_stb && reg_addr == ADDR_SUBSEC;
	endsequence
	sequence flag_rd;
		reg_rd_stb && reg_addr == ADDR_FLAGS;
	endsequence
	////////////////////////////////////////////////////////////////
	// Properties
	rd_hold_a: assert property (!reg_rd_stb |=> $stable(reg_rd_data))
		else $error("read data moved without a read");
	flags_read_a: assert property (flag_rd |=>
		reg_rd_data[1:0] == {$past(tamper_flag[0]), $past(tamper_flag[1])})
		else $error("flags read mismatch");
	irq_release_a: assert property (flag_rd ##1 $stable(tamper_flag) |-> irq_n)
		else $error("irq not released by flags read");
	irq_cause_a: assert property (!irq_n |-> |tamper_flag)
		else $error("irq without flag");
	flag_hold_a: assert property (tamper_flag[0] && !(reg_wr_stb &&
		reg_addr == ADDR_TAMPER1) |=> tamper_flag[0])
		else $error("flag cleared without disarm");
	stop_bit_a: assert property (reg_wr_stb && reg_addr == ADDR_SECONDS |=>
		osc_enable == !$past(reg_wr_data[STOP_BIT]))
		else $error("oscillator does not follow stop bit");
	subsec_zero_a: assert property (clk_wr ##[1:2] sub_rd |=> reg_rd_data == 8'h00)
		else $error("subsecond not zero after clock write");
	pull_off_a: assert property (tamper_flag[0] |-> !pull_enable[0])
		else $error("pull active after tamper");
endmodule : ttc_tamper_clock_chk

bind ttc_tamper_clock ttc_tamper_clock_chk #(.OSC_DIV(OSC_DIV)) i_chk (.clock(clock),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb), .reg_wr_data(reg_wr_data),
	.reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .irq_n(irq_n),
	.osc_enable(osc_enable), .tamper_flag(tamper_flag), .pull_enable(pull_enable));

/* tb_ttc_tamper_clock.sv */
// Register-level testbench for the tamper clock block
`timescale 1ns/100ps
module tb_ttc_tamper_clock
	import ttc_pkg::*;
;
	logic clock = 0;
	logic rst_n = 0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr_stb = 0;
	logic [7:0] reg_wr_data = 8'h00;
	logic reg_rd_stb = 0;
	logic [7:0] reg_rd_data;
	logic clock_access = 0;
	logic powerfail_out = 0;
	logic on_battery = 0;
	logic reset_out_active = 0;
	logic [1:0] pin;
	logic [1:0] pull_enable;
	logic [1:0] pull_to_high;
	logic [1:0] pull_strength_sel;
	logic irq_n;
	logic osc_enable;
	logic [1:0] tamper_flag;
	logic [1:0] sw_closed = 2'b10;
	logic [1:0] no_mode = 2'b01;
	logic [1:0] pol = 2'b10;
	logic [7:0] v;
	int err_count = 0;
	int checked = 0;
	// Short oscillator divider keeps subsecond ticks near 1300 clocks
	ttc_tamper_clock #(.OSC_DIV(4)) i_dut (.clock(clock), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb), .reg_wr_data(reg_wr_data),
		.reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .clock_access(clock_access),
		.powerfail_out(powerfail_out), .on_battery(on_battery),
		.reset_out_active(reset_out_active), .tamper_input_pin(pin),
		.pull_enable(pull_enable), .pull_to_high(pull_to_high),
		.pull_strength_sel(pull_strength_sel), .irq_n(irq_n), .osc_enable(osc_enable),
		.tamper_flag(tamper_flag));
	// Far side switches
	for (genvar c = 0; c < 2; c++) begin : g_sw
		ttc_switch_model i_sw (.sw_closed(sw_closed[c]), .no_mode(no_mode[c]), .pol(pol[c]),
			.pull_en(pull_enable[c]), .pull_hi(pull_to_high[c]), .pin(pin[c]));
	end
	always #2 clock = ~clock;
	////////////////////////////////////////////////////////////////
	// Access tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_stb <= 1;
		clock_access <= a < 8'h08;
		@(posedge clock);
		reg_wr_stb <= 0;
		clock_access <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd_stb <= 1;
		clock_access <= a < 8'h08;
		@(posedge clock);
		reg_rd_stb <= 0;
		clock_access <= 0;
		@(posedge clock);
		// Read data was launched one edge earlier and stands until the next read
		v = reg_rd_data;
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : idle
	// Subsecond moves only while user updates run
	task automatic sub_moving(input logic exp);
		idle(3000);
		rd(ADDR_SUBSEC);
		chk({7'h00, v != 8'h00}, {7'h00, exp});
	endtask : sub_moving
	task automatic conclude;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (60000) @(posedge clock);
		err_count++;
		conclude();
	end
	////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1;
		rd(ADDR_FLAGS);
		chk(v, 8'h00);
		rd(8'h10);
		chk(v, 8'h00);
		chk({irq_n, osc_enable, tamper_flag}, 8'h0c);
		wr(ADDR_HOURS, 8'hc5);
		rd(ADDR_HOURS);
		chk(v, 8'hc5);
		wr(ADDR_SUBSEC, 8'h55);
		rd(ADDR_SUBSEC);
		chk(v, 8'h00);
		wr(ADDR_SECONDS, 8'h80);
		idle(1);
		chk(osc_enable, 1'b0);
		wr(ADDR_SECONDS, 8'h00);
		idle(1);
		chk(osc_enable, 1'b1);
		sub_moving(1);
		wr(ADDR_TAMPER1, 8'he0);
		sw_closed[0] <= 1;
		idle(4);
		chk({irq_n, tamper_flag}, 8'h01);
		sub_moving(0);
		wr(ADDR_TAMPER2, 8'h94);
		sw_closed[1] <= 0;
		idle(1);
		chk({pull_enable[1], pull_to_high[1], pull_strength_sel[1]}, 8'h07);
		idle(3);
		chk({pull_enable[1], tamper_flag}, 8'h03);
		rd(ADDR_FLAGS);
		chk(v, 8'h03);
		chk({7'h00, irq_n}, 8'h01);
		wr(ADDR_TAMPER1, 8'h00);
		sw_closed[0] <= 0;
		idle(1);
		chk(tamper_flag, 2'b10);
		sub_moving(0);
		wr(ADDR_TAMPER2, 8'h00);
		sw_closed[1] <= 1;
		sub_moving(1);
		wr(ADDR_TAMPER1, 8'he0);
		sw_closed[0] <= 1;
		idle(4);
		wr(ADDR_TAMPER1, 8'ha0);
		idle(1);
		chk({irq_n, tamper_flag}, 8'h05);
		@(posedge clock);
		powerfail_out <= 1;
		idle(6);
		rd(ADDR_HALT);
		chk(v, 8'h00);
		powerfail_out <= 0;
		wr(ADDR_TAMPER1, 8'h00);
		sw_closed[0] <= 0;
		repeat (5) @(posedge clock);
		powerfail_out <= 1;
		idle(6);
		rd(ADDR_HALT);
		chk(v, 8'h40);
		powerfail_out <= 0;
		sub_moving(0);
		wr(ADDR_HALT, 8'h00);
		sub_moving(1);
		on_battery <= 1;
		wr(ADDR_TAMPER1, 8'he0);
		sw_closed[0] <= 1;
		idle(4);
		chk({irq_n, tamper_flag}, 8'h01);
		// Sampled closed-loop channel: an open switch outside the window goes unseen
		wr(ADDR_TAMPER2, 8'h9c);
		sw_closed[1] <= 0;
		idle(200);
		chk({pull_enable[1], tamper_flag[1]}, 8'h00);
		// Stopping the oscillator turns sampling into continuous monitoring
		wr(ADDR_SECONDS, 8'h80);
		idle(8);
		chk({pull_enable[1], tamper_flag[1]}, 8'h01);
		@(posedge clock);
		reset_out_active <= 1;
		idle(5);
		chk(irq_n, 1'b1);
		conclude();
	end
endmodule : tb_ttc_tamper_clock
